// File: fan_seq_pkg.sv
// Shared constants, register map and carrier types for the fan PWM sequencer
package fan_seq_pkg;

  // ****************************************************************
  // Widths and timing
  // ****************************************************************
  localparam int unsigned LEVEL_W            = 8;
  localparam int unsigned SPINUP_INTERVAL    = 64;   // Time-base periods of forced drive
  localparam int unsigned SPINUP_W           = 7;
  localparam int unsigned PCLK_MHZ           = 100;
  localparam int unsigned SHUTDOWN_PULSE_MIN_US = 30;
  localparam int unsigned SHUTDOWN_PULSE_MIN_CYC = SHUTDOWN_PULSE_MIN_US * PCLK_MHZ;

  // ****************************************************************
  // Register map (byte addresses)
  // ****************************************************************
  localparam logic [11:0] OFF_THRESH_LO = 12'h000;
  localparam logic [11:0] OFF_THRESH_HI = 12'h004;
  localparam logic [11:0] OFF_STATE     = 12'h008;
  localparam logic [11:0] OFF_IRQ_STAT  = 12'h00C;
  localparam logic [11:0] OFF_IRQ_MASK  = 12'h010;

  // ****************************************************************
  // Reset values of the thresholds
  // ****************************************************************
  localparam logic [LEVEL_W-1:0] RST_SHUTDOWN  = 8'h10;
  localparam logic [LEVEL_W-1:0] RST_RESTART   = 8'h1C;
  localparam logic [LEVEL_W-1:0] RST_SLEEP     = 8'h00;
  localparam logic [LEVEL_W-1:0] RST_HYST      = 8'h1C;
  localparam logic [LEVEL_W-1:0] RST_PWM_FLOOR = 8'h4D;
  localparam logic [LEVEL_W-1:0] RST_FULL_DUTY = 8'hB3;
  localparam logic [LEVEL_W-1:0] RST_OVERTEMP  = 8'hC4;

  // ****************************************************************
  // Interrupt bit positions
  // ****************************************************************
  localparam int unsigned IRQ_W        = 4;
  localparam int unsigned IRQ_OVERTEMP = 0;
  localparam int unsigned IRQ_SHUTDOWN = 1;
  localparam int unsigned IRQ_SLEEP    = 2;
  localparam int unsigned IRQ_WAKE     = 3;
  localparam logic [IRQ_W-1:0] RST_IRQ_MASK = 4'h0;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef struct packed {
    logic [LEVEL_W-1:0] sleep_hysteresis;
    logic [LEVEL_W-1:0] sleep_threshold;
    logic [LEVEL_W-1:0] restart_threshold;
    logic [LEVEL_W-1:0] shutdown_threshold;
  } thresh_lo_t;

  typedef struct packed {
    logic [LEVEL_W-1:0] overtemp_threshold;
    logic [LEVEL_W-1:0] full_duty_level;
    logic [LEVEL_W-1:0] pwm_floor;
  } thresh_hi_t;

  typedef enum logic [3:0] {
    ST_SHUTDOWN = 4'b0001,
    ST_STARTUP  = 4'b0010,
    ST_RUN      = 4'b0100,
    ST_SLEEP    = 4'b1000
  } seq_state_t;

endpackage

// File: thermal_fan_pwm_sequencer.sv
// Fan PWM sequencer: startup, sleep, shutdown, overtemperature flag, APB registers
//
// Summary of operation
// - Power-on forces drive high for 64 periods.
// - Waking from sleep retriggers the 64-period startup.
// - Duty follows the greater control input.
// - Primary above full-duty level gives 100% drive.
// - Primary above overtemp asserts fault, drive stays full.
// - Primary back below overtemp releases the fault.
// - Both inputs below sleep threshold enters sleep.
// - Only one input low keeps normal PWM.
// - Wake when an input exceeds sleep plus hysteresis.
// - Primary below shutdown threshold stops everything.
// - Time-base period is both logic step and PWM period.
// - In shutdown both outputs float.
// - Primary above restart after shutdown fully resets.
// - In sleep fault inactive, drive floats.
//
// Our own choices: the APB slave port and the address map.
`timescale 1ns/1ns
module thermal_fan_pwm_sequencer #(
  parameter int unsigned LEVEL_W  = fan_seq_pkg::LEVEL_W,
  parameter int unsigned SPINUP_N = fan_seq_pkg::SPINUP_INTERVAL
) (
  // Clock, reset, enable
  input  wire logic               pclk,
  input  wire logic               presetn,
  input  wire logic               ce,
  // APB slave
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [11:0]        paddr,
  input  wire logic [31:0]        pwdata,
  output logic      [31:0]        prdata,
  output logic                    pready,
  output logic                    pslverr,
  // Digitized control levels, produced on pclk
  input  wire logic [LEVEL_W-1:0] primary_temp_input,
  input  wire logic [LEVEL_W-1:0] secondary_control_input,
  // Time-base oscillator from the timing capacitor
  input  wire logic               timing_capacitor,
  // Fan drive pin
  output logic                    fan_drive_o,
  output logic                    fan_drive_oe,
  // Open-drain fault pin
  output logic                    overtemp_fault_n_o,
  output logic                    overtemp_fault_n_oe,
  // Interrupt
  output logic                    irq
);

  // ****************************************************************
  // Elaboration checks
  // ****************************************************************
  // Refused at elaboration, so a bad value never builds a counter that cannot finish
  if (LEVEL_W != fan_seq_pkg::LEVEL_W) begin : g_bad_level
    $error("LEVEL_W must match the register field width");
  end
  if (SPINUP_N < 1 || SPINUP_N >= (1 << fan_seq_pkg::SPINUP_W)) begin : g_bad_spinup
    $error("SPINUP_N out of counter range");
  end

  localparam logic [fan_seq_pkg::SPINUP_W-1:0] SPINUP_LAST =
    fan_seq_pkg::SPINUP_W'(SPINUP_N - 1);

  // ****************************************************************
  // Register storage
  // ****************************************************************
  fan_seq_pkg::thresh_lo_t        thr_lo_q;
  fan_seq_pkg::thresh_hi_t        thr_hi_q;
  logic [fan_seq_pkg::IRQ_W-1:0]  irq_stat_q;
  logic [fan_seq_pkg::IRQ_W-1:0]  irq_mask_q;
  logic [fan_seq_pkg::IRQ_W-1:0]  irq_event;

  fan_seq_pkg::seq_state_t        state_q;
  fan_seq_pkg::seq_state_t        state_d;
  logic [fan_seq_pkg::SPINUP_W-1:0] spinup_cnt_q;
  logic [LEVEL_W-1:0]             ramp_q;
  logic                           fault_q;
  logic                           drive_q;

  // ****************************************************************
  // Time-base synchroniser and period tick
  // ****************************************************************
  logic tb_meta_q;
  logic tb_sync_q;
  logic tb_prev_q;
  logic tick;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tb_meta_q <= 1'b0;
      tb_sync_q <= 1'b0;
      tb_prev_q <= 1'b0;
    end else if (ce) begin
      tb_meta_q <= timing_capacitor;
      tb_sync_q <= tb_meta_q;
      tb_prev_q <= tb_sync_q;
    end
  end

  // One tick per oscillator period steps the sequencer and restarts the ramp
  assign tick = tb_sync_q & ~tb_prev_q;

  // ****************************************************************
  // Comparator decisions
  // ****************************************************************
  logic [LEVEL_W-1:0] ctrl_level;
  logic [LEVEL_W:0]   wake_level;
  logic               below_shutdown;
  logic               above_restart;
  logic               both_asleep;
  logic               any_awake;
  logic               overtemp;

  // Greater input controls; switching follows their order continuously
  assign ctrl_level = (primary_temp_input > secondary_control_input) ?
                      primary_temp_input : secondary_control_input;

  // Extra bit so a large hysteresis cannot wrap below the sleep level
  assign wake_level = {1'b0, thr_lo_q.sleep_threshold} +
                      {1'b0, thr_lo_q.sleep_hysteresis};

  assign below_shutdown = primary_temp_input < thr_lo_q.shutdown_threshold;
  assign above_restart  = primary_temp_input > thr_lo_q.restart_threshold;

  // A zero sleep threshold can never be undercut, which disables sleep
  assign both_asleep = (primary_temp_input < thr_lo_q.sleep_threshold) &&
                       (secondary_control_input < thr_lo_q.sleep_threshold);

  assign any_awake = ({1'b0, primary_temp_input} > wake_level) ||
                     ({1'b0, secondary_control_input} > wake_level);

  assign overtemp = primary_temp_input > thr_hi_q.overtemp_threshold;

  // ****************************************************************
  // Sequencer state
  // ****************************************************************
  always_comb begin
    state_d = state_q;
    case (state_q)
      fan_seq_pkg::ST_SHUTDOWN: begin
        if (above_restart) begin
          state_d = fan_seq_pkg::ST_STARTUP;
        end
      end
      fan_seq_pkg::ST_STARTUP: begin
        if (tick && spinup_cnt_q == SPINUP_LAST) begin
          state_d = fan_seq_pkg::ST_RUN;
        end
      end
      fan_seq_pkg::ST_RUN: begin
        if (both_asleep) begin
          state_d = fan_seq_pkg::ST_SLEEP;
        end
      end
      fan_seq_pkg::ST_SLEEP: begin
        if (any_awake) begin
          state_d = fan_seq_pkg::ST_STARTUP;
        end
      end
      default: begin
        state_d = fan_seq_pkg::ST_SHUTDOWN;
      end
    endcase
    // Shutdown wins over every other state
    if (below_shutdown) begin
      state_d = fan_seq_pkg::ST_SHUTDOWN;
    end
  end

  // Reset lands in startup: power-on spins the fan up first
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= fan_seq_pkg::ST_STARTUP;
    end else if (ce) begin
      state_q <= state_d;
    end
  end

  // Startup counter counts time-base periods, cleared on every entry
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      spinup_cnt_q <= '0;
    end else if (ce) begin
      if (state_q != fan_seq_pkg::ST_STARTUP) begin
        spinup_cnt_q <= '0;
      end else if (tick) begin
        spinup_cnt_q <= spinup_cnt_q + 1'b1;
      end
    end
  end

  // ****************************************************************
  // PWM ramp
  // ****************************************************************
  // Ramp climbs from the floor one step per pclk and saturates at the
  // full-duty level; the span must fit inside one time-base period.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ramp_q <= fan_seq_pkg::RST_PWM_FLOOR;
    end else if (ce) begin
      if (tick) begin
        ramp_q <= thr_hi_q.pwm_floor;
      end else if (ramp_q < thr_hi_q.full_duty_level) begin
        ramp_q <= ramp_q + 1'b1;
      end
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      drive_q <= 1'b0;
    end else if (ce) begin
      case (state_d)
        fan_seq_pkg::ST_STARTUP: drive_q <= 1'b1;
        fan_seq_pkg::ST_RUN: begin
          if (ctrl_level >= thr_hi_q.full_duty_level) begin
            drive_q <= 1'b1;
          end else begin
            drive_q <= ctrl_level > ramp_q;
          end
        end
        default: drive_q <= 1'b0;
      endcase
    end
  end

  // Fault tracks the primary input only while the fan is active
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fault_q <= 1'b0;
    end else if (ce) begin
      fault_q <= overtemp &&
                 (state_d == fan_seq_pkg::ST_RUN ||
                  state_d == fan_seq_pkg::ST_STARTUP);
    end
  end

  // Shutdown floats the pins at once, without waiting for a clock edge
  assign fan_drive_o  = drive_q;
  assign fan_drive_oe = ~below_shutdown &&
                        (state_q == fan_seq_pkg::ST_RUN ||
                         state_q == fan_seq_pkg::ST_STARTUP);
  assign overtemp_fault_n_o  = 1'b0;
  assign overtemp_fault_n_oe = fault_q & ~below_shutdown;

  // ****************************************************************
  // Interrupt events
  // ****************************************************************
  always_comb begin
    irq_event = '0;
    irq_event[fan_seq_pkg::IRQ_OVERTEMP] = overtemp & ~fault_q & (state_d == fan_seq_pkg::ST_RUN);
    irq_event[fan_seq_pkg::IRQ_SHUTDOWN] = (state_d == fan_seq_pkg::ST_SHUTDOWN) &&
                                           (state_q != fan_seq_pkg::ST_SHUTDOWN);
    irq_event[fan_seq_pkg::IRQ_SLEEP]    = (state_d == fan_seq_pkg::ST_SLEEP) &&
                                           (state_q != fan_seq_pkg::ST_SLEEP);
    irq_event[fan_seq_pkg::IRQ_WAKE]     = (state_q == fan_seq_pkg::ST_SLEEP) &&
                                           (state_d == fan_seq_pkg::ST_STARTUP);
  end

  assign irq = |(irq_stat_q & irq_mask_q);

  // ****************************************************************
  // APB slave
  // ****************************************************************
  logic wr_en;
  logic rd_hit;

  // Zero wait states; a frozen block stalls the bus instead of losing writes
  assign pready = ce;
  assign wr_en  = psel & penable & pwrite & ce;

  always_comb begin
    case (paddr)
      fan_seq_pkg::OFF_THRESH_LO,
      fan_seq_pkg::OFF_THRESH_HI,
      fan_seq_pkg::OFF_STATE,
      fan_seq_pkg::OFF_IRQ_STAT,
      fan_seq_pkg::OFF_IRQ_MASK: rd_hit = 1'b1;
      default:                   rd_hit = 1'b0;
    endcase
  end

  assign pslverr = psel & penable & ~rd_hit;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      thr_lo_q <= '{sleep_hysteresis:   fan_seq_pkg::RST_HYST,
                    sleep_threshold:    fan_seq_pkg::RST_SLEEP,
                    restart_threshold:  fan_seq_pkg::RST_RESTART,
                    shutdown_threshold: fan_seq_pkg::RST_SHUTDOWN};
      thr_hi_q <= '{overtemp_threshold: fan_seq_pkg::RST_OVERTEMP,
                    full_duty_level:    fan_seq_pkg::RST_FULL_DUTY,
                    pwm_floor:          fan_seq_pkg::RST_PWM_FLOOR};
    end else if (wr_en) begin
      if (paddr == fan_seq_pkg::OFF_THRESH_LO) begin
        thr_lo_q <= pwdata[$bits(fan_seq_pkg::thresh_lo_t)-1:0];
      end
      if (paddr == fan_seq_pkg::OFF_THRESH_HI) begin
        thr_hi_q <= pwdata[$bits(fan_seq_pkg::thresh_hi_t)-1:0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_mask_q <= fan_seq_pkg::RST_IRQ_MASK;
    end else if (wr_en && paddr == fan_seq_pkg::OFF_IRQ_MASK) begin
      irq_mask_q <= pwdata[fan_seq_pkg::IRQ_W-1:0];
    end
  end

  // Write one clears; a new event in the same cycle keeps its bit set
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat_q <= '0;
    end else if (ce) begin
      if (wr_en && paddr == fan_seq_pkg::OFF_IRQ_STAT) begin
        irq_stat_q <= (irq_stat_q & ~pwdata[fan_seq_pkg::IRQ_W-1:0]) | irq_event;
      end else begin
        irq_stat_q <= irq_stat_q | irq_event;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
    end else if (ce && psel && !penable && !pwrite) begin
      case (paddr)
        fan_seq_pkg::OFF_THRESH_LO: prdata <= 32'(thr_lo_q);
        fan_seq_pkg::OFF_THRESH_HI: prdata <= 32'(thr_hi_q);
        fan_seq_pkg::OFF_STATE:     prdata <= {ctrl_level, 7'h00, fault_q, 5'h00,
                                               spinup_cnt_q, 4'(state_q)};
        fan_seq_pkg::OFF_IRQ_STAT:  prdata <= 32'(irq_stat_q);
        fan_seq_pkg::OFF_IRQ_MASK:  prdata <= 32'(irq_mask_q);
        default:                    prdata <= '0;
      endcase
    end
  end

endmodule

// File: fan_seq_checker.sv
// Concurrent checks on the fan PWM sequencer pins
`timescale 1ns/1ns
module fan_seq_checker #(
  parameter int unsigned LEVEL_W  = 8,
  parameter int unsigned SPINUP_N = 64
) (
  // Clock and reset
  input wire logic               pclk,
  input wire logic               presetn,
  // Level, time base and pins
  input wire logic [LEVEL_W-1:0] primary_temp_input,
  input wire logic               timing_capacitor,
  input wire logic               fan_drive_o,
  input wire logic               fan_drive_oe,
  input wire logic               overtemp_fault_n_o,
  input wire logic               overtemp_fault_n_oe
);
  localparam logic [LEVEL_W-1:0] SHUT = fan_seq_pkg::RST_SHUTDOWN;
  localparam logic [LEVEL_W-1:0] FULL = fan_seq_pkg::RST_FULL_DUTY;
  localparam logic [LEVEL_W-1:0] OT   = fan_seq_pkg::RST_OVERTEMP;
  logic [2:0] tc_q;
  logic [7:0] ticks_q;

  // ********
  // Ticks since drive enable; two ticks of slack absorb the sync delay
  // ********
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tc_q    <= 3'h0;
      ticks_q <= 8'h00;
    end else begin
      tc_q <= {tc_q[1:0], timing_capacitor};
      if (!fan_drive_oe) ticks_q <= 8'h00;
      else if (tc_q[1] && !tc_q[2] && ticks_q != 8'hFF) ticks_q <= ticks_q + 8'h01;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  chk_drive_float: assert property (primary_temp_input < SHUT |-> !fan_drive_oe)
    else $error("drive enabled below shutdown level");
  chk_fault_float: assert property (primary_temp_input < SHUT |-> !overtemp_fault_n_oe)
    else $error("fault driven below shutdown level");
  chk_fault_low: assert property (overtemp_fault_n_oe |-> !overtemp_fault_n_o)
    else $error("fault pin driven high");
  chk_spinup_high: assert property ($past(presetn) && $past(fan_drive_oe) && fan_drive_oe
    && int'(ticks_q) < SPINUP_N - 2 |-> fan_drive_o) else $error("drive low during spin-up");
  chk_full_duty: assert property ($past(presetn) && $past(fan_drive_oe)
    && $past(primary_temp_input) > FULL |-> fan_drive_o) else $error("drive low at full level");
  chk_fault_set: assert property ($past(presetn) && $past(fan_drive_oe)
    && $past(primary_temp_input) > OT && primary_temp_input >= SHUT |-> overtemp_fault_n_oe)
    else $error("fault missing above overtemp");
  chk_fault_clear: assert property ($past(presetn) && $past(fan_drive_oe)
    && $past(primary_temp_input) <= OT |-> !overtemp_fault_n_oe) else $error("fault stuck");
  chk_sleep_quiet: assert property (overtemp_fault_n_oe |-> fan_drive_oe)
    else $error("fault active while drive off");
endmodule

bind thermal_fan_pwm_sequencer fan_seq_checker #(.LEVEL_W(LEVEL_W), .SPINUP_N(SPINUP_N)) u_chk (
  .pclk(pclk), .presetn(presetn), .primary_temp_input(primary_temp_input),
  .timing_capacitor(timing_capacitor), .fan_drive_o(fan_drive_o), .fan_drive_oe(fan_drive_oe),
  .overtemp_fault_n_o(overtemp_fault_n_o), .overtemp_fault_n_oe(overtemp_fault_n_oe));

// File: fan_bay_model.sv
// Far-side model: time-base oscillator, fan transistor and fault pull-up
`timescale 1ns/1ns
module fan_bay_model #(
  parameter int HALF_NS = 600
) (
  // Time base
  output logic      timing_capacitor,
  // Sequencer pins
  input wire logic  fan_drive_o,
  input wire logic  fan_drive_oe,
  input wire logic  overtemp_fault_n_o,
  input wire logic  overtemp_fault_n_oe,
  // Resolved levels
  output logic      fan_on,
  output logic      fault_pin
);
  // Offset keeps oscillator edges away from pclk edges
  initial begin
    timing_capacitor = 1'b0;
    #3;
    forever #HALF_NS timing_capacitor = ~timing_capacitor;
  end
  // Base pull-down keeps the transistor off while the pin floats
  assign fan_on    = fan_drive_oe & fan_drive_o;
  // Pull-up holds the fault line high unless it is sunk
  assign fault_pin = ~(overtemp_fault_n_oe & ~overtemp_fault_n_o);
endmodule

// File: tb_thermal_fan_pwm_sequencer.sv
// Self-checking bench for the fan PWM sequencer
`timescale 1ns/1ns
module tb_thermal_fan_pwm_sequencer;
  localparam int PER = 120;  // pclk cycles in one time-base period
  logic        pclk, presetn, ce, psel, penable, pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        pready, pslverr, err, tcap, irq;
  logic        drv, drv_oe, flt, flt_oe, fan_on, fault_pin;
  logic [7:0]  pri, sec;
  int          n_errors, total_checks, cyc;

  thermal_fan_pwm_sequencer dut (
    .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .primary_temp_input(pri), .secondary_control_input(sec), .timing_capacitor(tcap),
    .fan_drive_o(drv), .fan_drive_oe(drv_oe), .overtemp_fault_n_o(flt),
    .overtemp_fault_n_oe(flt_oe), .irq(irq));
  fan_bay_model far_side (
    .timing_capacitor(tcap), .fan_drive_o(drv), .fan_drive_oe(drv_oe),
    .overtemp_fault_n_o(flt), .overtemp_fault_n_oe(flt_oe), .fan_on(fan_on),
    .fault_pin(fault_pin));

  // ********
  // Helpers
  // ********
  task automatic check(input string w, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %h seen %h", w, exp, seen);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Let the write land before the caller looks at irq or pins
    @(negedge pclk);
  endtask
  task automatic rdchk(input string w, input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    check(w, rd, e);
  endtask
  task automatic st(input logic [3:0] e);
    apb(1'b0, fan_seq_pkg::OFF_STATE, 32'h0);
    check("state", rd & 32'h0000000F, {28'h0, e});
  endtask
  task automatic lv(input logic [7:0] p, input logic [7:0] s);
    @(posedge pclk);
    pri <= p;
    sec <= s;
    repeat (4) @(posedge pclk);
  endtask
  // Any PER consecutive cycles hold exactly one ramp period
  task automatic duty(input int e);
    int h;
    h = 0;
    repeat (3 * PER) @(posedge pclk);
    repeat (PER) begin
      @(posedge pclk);
      h += fan_on;
    end
    check("duty", h, e);
  endtask
  task automatic ticks(input int n);
    repeat (n) @(posedge tcap);
    repeat (4) @(posedge pclk);
  endtask
  // With the enable low nothing may move, not even the PWM level
  task automatic freeze();
    logic held;
    int   moved;
    @(posedge pclk);
    ce <= 1'b0;
    @(posedge pclk);
    held = fan_on;
    moved = 0;
    repeat (PER) begin
      @(posedge pclk);
      moved += int'(fan_on != held);
    end
    check("pready", pready, 32'h0);
    check("frozen", moved, 32'h0);
    ce <= 1'b1;
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 60000) begin
      n_errors++;
      complete_run();
    end
  end

  // ********
  // Tests
  // ********
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    ce = 1'b1;
    pri = 8'h80;
    sec = 8'h60;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    rdchk("thresh_lo", fan_seq_pkg::OFF_THRESH_LO, 32'h1C001C10);
    rdchk("thresh_hi", fan_seq_pkg::OFF_THRESH_HI, 32'h00C4B34D);
    rdchk("irq_mask", fan_seq_pkg::OFF_IRQ_MASK, 32'h00000000);
    apb(1'b1, 12'h014, 32'hFFFFFFFF);
    rdchk("unmapped", 12'h014, 32'h00000000);
    check("slverr", err, 32'h1);
    st(4'h2);
    check("fan", fan_on, 32'h1);
    ticks(60);
    st(4'h2);
    ticks(6);
    st(4'h4);
    $display("test power-up done");
    duty(8'h80 - 8'h4D);
    lv(8'h60, 8'h90);
    duty(8'h90 - 8'h4D);
    lv(8'hB5, 8'h60);
    duty(PER);
    lv(8'hD0, 8'h60);
    duty(PER);
    check("fault", fault_pin, 32'h0);
    check("irq", irq, 32'h0);
    rdchk("irq_stat", fan_seq_pkg::OFF_IRQ_STAT, 32'h00000001);
    apb(1'b1, fan_seq_pkg::OFF_IRQ_MASK, 32'h0000000F);
    check("irq", irq, 32'h1);
    lv(8'h80, 8'h60);
    check("fault", fault_pin, 32'h1);
    duty(8'h80 - 8'h4D);
    apb(1'b1, fan_seq_pkg::OFF_IRQ_STAT, 32'h00000001);
    check("irq", irq, 32'h0);
    $display("test duty and fault done");
    apb(1'b1, fan_seq_pkg::OFF_THRESH_LO, 32'h1C301C10);
    lv(8'h20, 8'h80);
    st(4'h4);
    duty(8'h80 - 8'h4D);
    lv(8'h20, 8'h20);
    st(4'h8);
    check("drive_oe", drv_oe, 32'h0);
    check("fault", fault_pin, 32'h1);
    lv(8'h20, 8'h48);
    st(4'h8);
    lv(8'h20, 8'h50);
    st(4'h2);
    ticks(60);
    st(4'h2);
    ticks(6);
    st(4'h4);
    rdchk("irq_stat", fan_seq_pkg::OFF_IRQ_STAT, 32'h0000000C);
    apb(1'b1, fan_seq_pkg::OFF_IRQ_STAT, 32'h0000000C);
    freeze();
    $display("test sleep done");
    lv(8'hD0, 8'h80);
    lv(8'h05, 8'h80);
    repeat (fan_seq_pkg::SHUTDOWN_PULSE_MIN_CYC) @(posedge pclk);
    st(4'h1);
    check("drive_oe", drv_oe, 32'h0);
    check("fault", fault_pin, 32'h1);
    rdchk("irq_stat", fan_seq_pkg::OFF_IRQ_STAT, 32'h00000003);
    lv(8'h80, 8'h80);
    st(4'h2);
    check("fault", fault_pin, 32'h1);
    check("fan", fan_on, 32'h1);
    $display("test shutdown done");
    complete_run();
  end
endmodule
